// *** usb_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_core_model (
  input  wire logic        i_clk,   // system clock
  output var  logic [15:0] o_evt,   // core event image
  output var  logic        o_iso,   // iso packet loaded
  output var  logic        o_upd,   // dma state update
  output var  logic        o_eop,   // eop descriptor done
  output var  logic [6:0]  o_token  // token address field
);
  // ---------------------------------------------------------------
  // event strobes
  // ---------------------------------------------------------------
  // quiet until asked, so no stray event lands during reset
  initial begin
    o_evt = 16'h0000;
    o_iso = 1'h0;
    o_upd = 1'h0;
    o_eop = 1'h0;
    o_token = 7'h00;
  end
  // raise just after an edge; the caller drops it one cycle later
  task automatic raise(input logic [15:0] e, input logic [2:0] s);
    @(posedge i_clk);
    o_evt <= e;
    {o_iso, o_upd, o_eop} <= s;
  endtask
  task automatic drop();
    @(posedge i_clk);
    o_evt <= 16'h0000;
    {o_iso, o_upd, o_eop} <= 3'h0;
  endtask
  // token address as handed out by the host's address request
  task automatic token(input logic [6:0] a);
    @(posedge i_clk);
    o_token <= a;
  endtask
endmodule // usb_core_model
`default_nettype wire

// *** usb_ctrl_power_irq_rxdma_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_ctrl_power_irq_rxdma_regs_test;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  localparam logic [29:0] DESC = 30'h0ABCDEF1;
  localparam logic [31:0] BUFA = 32'h80001234;
  localparam logic [15:0] PKT = 16'h0040;
  localparam logic [15:0] FREE = 16'h01C0;
  logic clk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, host = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, dbuf = 32'h0;
  logic [29:0] ddesc = 30'h0;
  logic [15:0] dpkt = 16'h0, dfree = 16'h0, evt, sop_len;
  logic [6:0] token, target;
  logic pready, er, slverr, dinpkt = 1'h0, upd, eop, iso, match, zlp, siso, sop_wr;
  logic oe_b, hs_neg, res_drv, susp_out, rxq_irq, irq;
  int n_mismatch = 0;
  int check_count = 0;
  usb_core_model i_usb_core_model (.i_clk(clk), .o_evt(evt), .o_iso(iso), .o_upd(upd),
    .o_eop(eop), .o_token(token));
  usb_ctrl_regs i_usb_ctrl_regs (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(slverr), .I_HOST_ROLE(host),
    .I_EVT(evt), .I_DMA_UPD(upd), .I_DMA_DESC(ddesc), .I_DMA_BUF(dbuf), .I_DMA_PKT(dpkt),
    .I_DMA_FREE(dfree), .I_DMA_INPKT(dinpkt), .I_DMA_EOP(eop), .I_ISO_LOADED(iso),
    .I_TOKEN_ADDR(token), .O_TOKEN_MATCH(match), .O_TARGET_ADDR(target), .O_SEND_ZLP(zlp),
    .O_SEND_ISO(siso), .O_WRITE_SOP_LEN(sop_wr), .O_SOP_LEN(sop_len), .O_LINE_OE_B(oe_b),
    .O_HS_NEGOTIATE(hs_neg), .O_RESUME_DRV(res_drv), .O_SUSPEND_OUT(susp_out),
    .O_RXQ_IRQ(rxq_irq), .O_IRQ(irq));
  always #25 clk = ~clk;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // apb master: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    er = slverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'h0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic pulse(input logic [15:0] e, input logic [2:0] s);
    i_usb_core_model.raise(e, s);
    i_usb_core_model.drop();
    #1;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_dma();
    @(posedge clk);
    {ddesc, dbuf, dpkt, dfree, dinpkt} <= {DESC, BUFA, PKT, FREE, 1'h1};
    pulse(16'h0000, 3'h2);
    rdchk(usb_regs_pkg::OFS_RX_DESC_PTR, {DESC, 2'h1}, "desc");
    rdchk(usb_regs_pkg::OFS_RX_BUF_ADDR, BUFA, "buf");
    rdchk(usb_regs_pkg::OFS_RX_LENGTHS, {PKT, FREE}, "lengths");
    rdchk(usb_regs_pkg::OFS_RX_BYTECNT, {PKT, FREE}, "counts");
    apb(1'h1, usb_regs_pkg::OFS_RX_DESC_PTR, 32'hFFFFFFFF);
    rdchk(usb_regs_pkg::OFS_RX_DESC_PTR, 32'hFFFFFFFD, "desc wr");
  endtask
  // eop loads the pointer, then the first descriptor length goes out once
  task automatic t_comp();
    int hits = 0;
    logic [15:0] len = 16'h0;
    pulse(16'h0000, 3'h1);
    for (int i = 0; i < 3; i++) begin
      #1;
      if (sop_wr === 1'h1) begin
        hits++;
        len = sop_len;
      end
      @(posedge clk);
    end
    chk("sop hits", hits, 1);
    chk("sop len", len, PKT);
    chk("rxq set", rxq_irq, 1);
    rdchk(usb_regs_pkg::OFS_RX_COMP_PTR, {DESC, 2'h0}, "comp");
    apb(1'h1, usb_regs_pkg::OFS_RX_COMP_PTR, {~DESC, 2'h0});
    chk("rxq miss", rxq_irq, 1);
    apb(1'h1, usb_regs_pkg::OFS_RX_COMP_PTR, {DESC, 2'h0});
    chk("rxq hit", rxq_irq, 0);
    apb(1'h1, usb_regs_pkg::OFS_RX_COMP_PTR, 32'h55555555);
    chk("rxq wb", rxq_irq, 1);
    rdchk(usb_regs_pkg::OFS_RX_COMP_PTR, 32'h55555554, "comp wb");
  endtask
  task automatic t_addr();
    apb(1'h1, usb_regs_pkg::OFS_FUNC_ADDR, 32'h000000D5);
    rdchk(usb_regs_pkg::OFS_FUNC_ADDR, 32'h55, "function_address");
    i_usb_core_model.token(7'h54);
    #1 chk("no match", match, 0);
    i_usb_core_model.token(7'h55);
    #1 chk("match", match, 1);
    @(posedge clk);
    host <= 1'h1;
    #1 chk("host match", match, 0);
    chk("target", target, 32'h55);
    host <= 1'h0;
  endtask
  task automatic t_power();
    rdchk(usb_regs_pkg::OFS_POWER, 32'h20, "power rst");
    chk("hs neg", hs_neg, 1);
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'h60);
    chk("attach", oe_b, 0);
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'h18);
    chk("detach", oe_b, 1);
    chk("fs only", hs_neg, 0);
    rdchk(usb_regs_pkg::OFS_POWER, 32'h00, "ro bits");
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'h20);
    pulse(16'h1000, 3'h0);
    rdchk(usb_regs_pkg::OFS_POWER, 32'h30, "hs done");
    pulse(16'h2000, 3'h0);
    chk("susp gated", susp_out, 0);
    rdchk(usb_regs_pkg::OFS_POWER, 32'h32, "susp");
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'h25);
    rdchk(usb_regs_pkg::OFS_POWER, 32'h35, "resume clr");
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'h21);
    pulse(16'h2000, 3'h0);
    chk("susp out", susp_out, 1);
    apb(1'h0, usb_regs_pkg::OFS_TX_IRQ_STAT, 32'h0);
    rdchk(usb_regs_pkg::OFS_POWER, 32'h31, "read clr");
    chk("susp off", susp_out, 0);
    @(posedge clk);
    host <= 1'h1;
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'h28);
    rdchk(usb_regs_pkg::OFS_POWER, 32'h38, "host rst");
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'h22);
    pulse(16'h4000, 3'h0);
    rdchk(usb_regs_pkg::OFS_POWER, 32'h36, "auto res");
    chk("res drv", res_drv, 1);
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'h22);
    chk("res end", res_drv, 0);
    pulse(16'h8000, 3'h0);
    rdchk(usb_regs_pkg::OFS_POWER, 32'h2A, "bus rst");
    host <= 1'h0;
  endtask
  task automatic t_irq();
    apb(1'h1, usb_regs_pkg::OFS_WRAP_CTRL, 32'h1);
    rdchk(usb_regs_pkg::OFS_WRAP_CTRL, 32'h1, "direct");
    pulse(16'h023F, 3'h0);
    chk("irq off", irq, 0);
    apb(1'h1, usb_regs_pkg::OFS_TX_IRQ_EN, 32'hFFFFFFFF);
    rdchk(usb_regs_pkg::OFS_TX_IRQ_EN, 32'h1F, "tx en");
    chk("irq on", irq, 1);
    apb(1'h1, usb_regs_pkg::OFS_TX_IRQ_EN, 32'h2);
    chk("irq other", irq, 0);
    apb(1'h1, usb_regs_pkg::OFS_TX_IRQ_EN, 32'h1);
    rdchk(usb_regs_pkg::OFS_TX_IRQ_STAT, 32'h11, "tx stat");
    chk("irq clr", irq, 0);
    rdchk(usb_regs_pkg::OFS_TX_IRQ_STAT, 32'h0, "tx rc");
    apb(1'h1, usb_regs_pkg::OFS_RX_IRQ_EN, 32'hFFFFFFFF);
    chk("irq rx", irq, 1);
    rdchk(usb_regs_pkg::OFS_RX_IRQ_EN, 32'h1E, "rx en");
    rdchk(usb_regs_pkg::OFS_RX_IRQ_STAT, 32'h1E, "rx stat");
    chk("irq rx clr", irq, 0);
    rdchk(usb_regs_pkg::OFS_RX_IRQ_STAT, 32'h0, "rx rc");
    rdchk(8'h30, 32'h0, "unmapped");
    chk("slverr", er, 1);
  endtask
  // zero length answer before the frame start, the real packet after it
  task automatic t_iso();
    apb(1'h1, usb_regs_pkg::OFS_POWER, 32'hA0);
    pulse(16'h0000, 3'h4);
    i_usb_core_model.raise(16'h0400, 3'h0);
    #1 chk("zlp", zlp, 1);
    chk("held", siso, 0);
    i_usb_core_model.drop();
    pulse(16'h0800, 3'h0);
    i_usb_core_model.raise(16'h0400, 3'h0);
    #1 chk("iso", siso, 1);
    i_usb_core_model.drop();
  endtask
  // ---------------------------------------------------------------
  // sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    t_power();
    t_dma();
    t_comp();
    t_addr();
    t_irq();
    t_iso();
    stop_test();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    #(5000 * 50);
    n_mismatch++;
    stop_test();
  end
endmodule // usb_ctrl_power_irq_rxdma_regs_test
`default_nettype wire

// *** usb_ctrl_regs.sv ***
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// - rx dma in-packet flag at bit 0
// - descriptor pointer bits 31-2, bit 1 zero
// - full 32-bit buffer byte address
// - packet byte total in bits 31-16
// - free buffer bytes in bits 15-0
// - completion pointer holds last eop descriptor
// - compare mode match clears queue irq
// - readback mode loads pointer, raises irq
// - peripheral matches token address to function_address
// - host uses function_address as target address
// - iso wait: zero length before sof, peripheral role only
// - soft attach drives or tristates lines in peripheral role; host always drives
// - high speed allow resets to one
// - high speed active set after negotiation
// - bus reset bit set by bus signalling
// - resume bit drives resume signalling only while the suspend bit is set
// - host sets resume on detected resume
// - suspend bit set/cleared per role
// - suspend output gated by enable bit
// - tx irq status bits 4-0
// - rx irq status bits 4-1
// - reading irq status clears it
// - tx irq enable bits 4-0
module usb_ctrl_regs (
  input  wire logic                    I_CLK_SYS,      // 20 MHz system clock
  input  wire logic                    I_RST_B,        // async reset, low
  input  wire logic                    I_PSEL,         // apb select
  input  wire logic                    I_PENABLE,      // apb access phase
  input  wire logic                    I_PWRITE,       // apb direction
  input  wire logic [7:0]              I_PADDR,        // apb byte address
  input  wire logic [31:0]             I_PWDATA,       // apb write data
  output logic      [31:0]             O_PRDATA,       // apb read data
  output logic                         O_PREADY,       // apb ready
  output logic                         O_PSLVERR,      // apb error
  input  wire logic                    I_HOST_ROLE,    // 1 host, 0 peripheral
  input  wire usb_regs_pkg::core_evt_t I_EVT,          // core event pulses
  input  wire logic                    I_DMA_UPD,      // rx dma state update
  input  wire logic [29:0]             I_DMA_DESC,     // dma descriptor ptr
  input  wire logic [31:0]             I_DMA_BUF,      // dma buffer address
  input  wire logic [15:0]             I_DMA_PKT,      // dma packet total
  input  wire logic [15:0]             I_DMA_FREE,     // dma free bytes
  input  wire logic                    I_DMA_INPKT,    // dma inside packet
  input  wire logic                    I_DMA_EOP,      // eop descriptor done
  input  wire logic                    I_ISO_LOADED,   // iso packet loaded
  input  wire logic [6:0]              I_TOKEN_ADDR,   // token address field
  output logic                         O_TOKEN_MATCH,  // token is for us
  output logic      [6:0]              O_TARGET_ADDR,  // host target address
  output logic                         O_SEND_ZLP,     // send zero length
  output logic                         O_SEND_ISO,     // send readied iso
  output logic                         O_WRITE_SOP_LEN,// write sop word 3
  output logic      [15:0]             O_SOP_LEN,      // length to write
  output logic                         O_LINE_OE_B,    // d+/d- enable, low
  output logic                         O_HS_NEGOTIATE, // allow hs chirp
  output logic                         O_RESUME_DRV,   // drive resume
  output logic                         O_SUSPEND_OUT,  // suspend mode out
  output logic                         O_RXQ_IRQ,      // rx queue interrupt
  output logic                         O_IRQ           // endpoint interrupt
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic known;
  assign acc       = I_PSEL & I_PENABLE;
  assign wr        = acc & I_PWRITE;
  assign rd        = acc & ~I_PWRITE;
  assign O_PREADY  = 1'b1;  // zero wait states, simplest for software
  assign known     = (I_PADDR[1:0] == 2'b00) && (I_PADDR <= usb_regs_pkg::OFS_WRAP_CTRL);
  assign O_PSLVERR = acc & ~known;

  // ---------------------------------------------------------------
  // rx dma state words
  // ---------------------------------------------------------------
  logic [29:0] desc_ptr_q;
  logic [31:0] buf_addr_q;
  logic [15:0] pkt_total_q;
  logic [15:0] free_q;
  logic [15:0] sop_total_q;
  logic [15:0] free_cnt_q;
  logic        in_pkt_q;
  logic        sop_wr_q;

  // hardware update beats a same-cycle software write
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      desc_ptr_q  <= usb_regs_pkg::RST_PTR30;
      buf_addr_q  <= 32'h00000000;
      pkt_total_q <= 16'h0000;
      free_q      <= 16'h0000;
      sop_total_q <= 16'h0000;
      free_cnt_q  <= 16'h0000;
      in_pkt_q    <= 1'b0;
    end else if (I_DMA_UPD) begin
      desc_ptr_q  <= I_DMA_DESC;
      buf_addr_q  <= I_DMA_BUF;
      pkt_total_q <= I_DMA_PKT;
      free_q      <= I_DMA_FREE;
      sop_total_q <= I_DMA_PKT;
      free_cnt_q  <= I_DMA_FREE;
      in_pkt_q    <= I_DMA_INPKT;
    end else if (wr) begin
      if (I_PADDR == usb_regs_pkg::OFS_RX_DESC_PTR) begin
        desc_ptr_q <= I_PWDATA[31:2];
        in_pkt_q   <= I_PWDATA[usb_regs_pkg::POS_IN_PACKET];
      end
      if (I_PADDR == usb_regs_pkg::OFS_RX_BUF_ADDR) begin
        buf_addr_q <= I_PWDATA;
      end
      if (I_PADDR == usb_regs_pkg::OFS_RX_LENGTHS) begin
        pkt_total_q <= I_PWDATA[31:16];
        free_q      <= I_PWDATA[15:0];
      end
      if (I_PADDR == usb_regs_pkg::OFS_RX_BYTECNT) begin
        sop_total_q <= I_PWDATA[31:16];
        free_cnt_q  <= I_PWDATA[15:0];
      end
    end
  end

  // eop processing writes the packet total into the sop descriptor
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sop_wr_q  <= 1'b0;
      O_SOP_LEN <= 16'h0000;
    end else begin
      sop_wr_q <= I_DMA_EOP;
      if (I_DMA_EOP) begin
        O_SOP_LEN <= pkt_total_q;
      end
    end
  end
  assign O_WRITE_SOP_LEN = sop_wr_q;

  // ---------------------------------------------------------------
  // completion pointer
  // ---------------------------------------------------------------
  logic [29:0] comp_q;
  logic        rxq_irq_q;
  logic        comp_acc;
  logic        mode_bit;
  assign comp_acc = acc && (I_PADDR == usb_regs_pkg::OFS_RX_COMP_PTR);
  assign mode_bit = I_PWDATA[usb_regs_pkg::POS_MODE_BIT];

  // dma completion raises the irq and wins over a compare clear
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      comp_q    <= usb_regs_pkg::RST_PTR30;
      rxq_irq_q <= 1'b0;
    end else if (I_DMA_EOP) begin
      comp_q    <= I_DMA_DESC;
      rxq_irq_q <= 1'b1;
    end else if (comp_acc && I_PWRITE && mode_bit) begin
      comp_q    <= I_PWDATA[31:2];
      rxq_irq_q <= 1'b1;
    end else if (comp_acc && I_PWRITE && (I_PWDATA[31:2] == comp_q)) begin
      rxq_irq_q <= 1'b0;
    end
  end
  assign O_RXQ_IRQ = rxq_irq_q;

  // ---------------------------------------------------------------
  // function address and power management
  // ---------------------------------------------------------------
  logic [6:0]           function_address_q;
  usb_regs_pkg::power_t pwr_q;
  logic                 pwr_wr;
  logic                 irq_rd;
  assign pwr_wr = wr && (I_PADDR == usb_regs_pkg::OFS_POWER);
  assign irq_rd = rd && ((I_PADDR == usb_regs_pkg::OFS_TX_IRQ_STAT) ||
                         (I_PADDR == usb_regs_pkg::OFS_RX_IRQ_STAT));

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      function_address_q <= usb_regs_pkg::RST_FUNCTION_ADDRESS;
    end else if (wr && (I_PADDR == usb_regs_pkg::OFS_FUNC_ADDR)) begin
      function_address_q <= I_PWDATA[6:0];
    end
  end

  assign O_TOKEN_MATCH = ~I_HOST_ROLE & (I_TOKEN_ADDR == function_address_q);
  assign O_TARGET_ADDR = function_address_q;

  // hardware sets win over software clears on every status bit
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pwr_q <= usb_regs_pkg::RST_POWER;
    end else begin
      if (pwr_wr) begin
        pwr_q.iso_wait_for_frame    <= I_PWDATA[usb_regs_pkg::POS_ISO_WAIT];
        pwr_q.soft_attach           <= I_PWDATA[usb_regs_pkg::POS_SOFT_ATTACH];
        pwr_q.high_speed_allow      <= I_PWDATA[usb_regs_pkg::POS_HS_ALLOW];
        pwr_q.suspend_output_enable <= I_PWDATA[usb_regs_pkg::POS_ENSUSP];
      end
      // hs status, cleared by a new bus reset
      if (I_EVT.hs_done && pwr_q.high_speed_allow) begin
        pwr_q.high_speed_active <= 1'b1;
      end else if (I_EVT.bus_reset_seen) begin
        pwr_q.high_speed_active <= 1'b0;
      end
      // bus reset: writable only in host role
      if (I_EVT.bus_reset_seen) begin
        pwr_q.bus_reset <= 1'b1;
      end else if (pwr_wr && I_HOST_ROLE) begin
        pwr_q.bus_reset <= I_PWDATA[usb_regs_pkg::POS_BUSRESET];
      end else if (!I_HOST_ROLE) begin
        pwr_q.bus_reset <= 1'b0;
      end
      // resume
      if (I_HOST_ROLE && I_EVT.resume_seen && pwr_q.suspend_state) begin
        pwr_q.resume <= 1'b1;
      end else if (pwr_wr) begin
        pwr_q.resume <= I_PWDATA[usb_regs_pkg::POS_RESUME];
      end
      // suspend
      if (!I_HOST_ROLE && I_EVT.suspend_seen) begin
        pwr_q.suspend_state <= 1'b1;
      end else if (pwr_wr && I_HOST_ROLE) begin
        pwr_q.suspend_state <= I_PWDATA[usb_regs_pkg::POS_SUSPEND];
      end else if (!I_HOST_ROLE && (irq_rd || (pwr_wr && I_PWDATA[usb_regs_pkg::POS_RESUME]))) begin
        pwr_q.suspend_state <= 1'b0;
      end
    end
  end

  // line and speed controls straight from the register bits; the host role always enables the lines
  assign O_LINE_OE_B    = I_HOST_ROLE ? 1'b0 : ~pwr_q.soft_attach;
  assign O_HS_NEGOTIATE = pwr_q.high_speed_allow;
  assign O_RESUME_DRV   = pwr_q.resume & pwr_q.suspend_state;
  assign O_SUSPEND_OUT  = pwr_q.suspend_state & pwr_q.suspend_output_enable;

  // ---------------------------------------------------------------
  // iso update: hold loaded packet until sof
  // ---------------------------------------------------------------
  logic iso_hold_q;
  logic iso_mode;
  assign iso_mode = pwr_q.iso_wait_for_frame & ~I_HOST_ROLE;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      iso_hold_q <= 1'b0;
    end else if (I_ISO_LOADED) begin
      iso_hold_q <= 1'b1;
    end else if (I_EVT.sof_token || !iso_mode) begin
      iso_hold_q <= 1'b0;
    end
  end
  assign O_SEND_ZLP = iso_mode & iso_hold_q & I_EVT.in_token;
  assign O_SEND_ISO = I_EVT.in_token & ~(iso_mode & iso_hold_q);

  // ---------------------------------------------------------------
  // endpoint interrupts
  // ---------------------------------------------------------------
  logic [4:0] tx_stat_q;
  logic [4:0] rx_stat_q;
  logic [4:0] tx_en_q;
  logic [4:0] rx_en_q;
  logic       direct_q;
  logic       tx_rd;
  logic       rx_rd;
  assign tx_rd = rd && (I_PADDR == usb_regs_pkg::OFS_TX_IRQ_STAT);
  assign rx_rd = rd && (I_PADDR == usb_regs_pkg::OFS_RX_IRQ_STAT);

  // one tx and one rx flop per endpoint; a set on the read cycle survives
  for (genvar g = 0; g < 5; g++) begin : g_ep
    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
        tx_stat_q[g] <= 1'b0;
        rx_stat_q[g] <= 1'b0;
      end else begin
        if (I_EVT.tx_irq_set[g]) begin
          tx_stat_q[g] <= 1'b1;
        end else if (tx_rd) begin
          tx_stat_q[g] <= 1'b0;
        end
        if (I_EVT.rx_irq_set[g] && (g != 0)) begin
          rx_stat_q[g] <= 1'b1;
        end else if (rx_rd) begin
          rx_stat_q[g] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tx_en_q  <= usb_regs_pkg::RST_IRQ_EN;
      rx_en_q  <= usb_regs_pkg::RST_IRQ_EN;
      direct_q <= 1'b0;
    end else if (wr) begin
      if (I_PADDR == usb_regs_pkg::OFS_TX_IRQ_EN) begin
        tx_en_q <= I_PWDATA[4:0];
      end
      if (I_PADDR == usb_regs_pkg::OFS_RX_IRQ_EN) begin
        rx_en_q <= {I_PWDATA[4:1], 1'b0};
      end
      if (I_PADDR == usb_regs_pkg::OFS_WRAP_CTRL) begin
        direct_q <= I_PWDATA[usb_regs_pkg::POS_DIRECT_IRQ];
      end
    end
  end

  assign O_IRQ = |(tx_stat_q & tx_en_q) | |(rx_stat_q & rx_en_q);

  // ---------------------------------------------------------------
  // read mux (registered data would add a wait; kept combinational)
  // ---------------------------------------------------------------
  always_comb begin
    O_PRDATA = 32'h00000000;
    if (rd) begin
      unique case (I_PADDR)
        usb_regs_pkg::OFS_RX_DESC_PTR: O_PRDATA = {desc_ptr_q, 1'b0, in_pkt_q};
        usb_regs_pkg::OFS_RX_BUF_ADDR: O_PRDATA = buf_addr_q;
        usb_regs_pkg::OFS_RX_LENGTHS:  O_PRDATA = {pkt_total_q, free_q};
        usb_regs_pkg::OFS_RX_BYTECNT:  O_PRDATA = {sop_total_q, free_cnt_q};
        usb_regs_pkg::OFS_RX_COMP_PTR: O_PRDATA = {comp_q, 2'b00};
        usb_regs_pkg::OFS_FUNC_ADDR:   O_PRDATA = {25'h0000000, function_address_q};
        usb_regs_pkg::OFS_POWER:       O_PRDATA = {24'h000000, pwr_q};
        usb_regs_pkg::OFS_TX_IRQ_STAT: O_PRDATA = {27'h0000000, tx_stat_q};
        usb_regs_pkg::OFS_RX_IRQ_STAT: O_PRDATA = {27'h0000000, rx_stat_q[4:1], 1'b0};
        usb_regs_pkg::OFS_TX_IRQ_EN:   O_PRDATA = {27'h0000000, tx_en_q};
        usb_regs_pkg::OFS_RX_IRQ_EN:   O_PRDATA = {27'h0000000, rx_en_q};
        usb_regs_pkg::OFS_WRAP_CTRL:   O_PRDATA = {31'h00000000, direct_q};
        default:                       O_PRDATA = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  // a tx status read with no fresh event and no live rx pair must drop the request
  irq_gating_a: assert property (tx_rd && !(|I_EVT.tx_irq_set)
                                 && !(|I_EVT.rx_irq_set) && !(|(rx_stat_q & rx_en_q))
                                 |=> !O_IRQ)
    else $error("endpoint irq not dropped");
  tx_rdclr_a: assert property (tx_rd && !(|I_EVT.tx_irq_set) |=> tx_stat_q == 5'h00)
    else $error("tx status not cleared by read");
  rx_bit0_a: assert property (rx_stat_q[0] == 1'b0)
    else $error("rx status bit 0 set");
  comp_wb_a: assert property (comp_acc && I_PWRITE && mode_bit && !I_DMA_EOP
                              |=> rxq_irq_q && comp_q == $past(I_PWDATA[31:2]))
    else $error("readback mode failed");
  comp_match_a: assert property (comp_acc && I_PWRITE && !mode_bit && !I_DMA_EOP
                                 && I_PWDATA[31:2] == comp_q |=> !rxq_irq_q)
    else $error("compare mode did not clear");
  susp_out_a: assert property (O_SUSPEND_OUT |-> pwr_q.suspend_output_enable)
    else $error("suspend out without enable");
  hs_status_a: assert property ($rose(pwr_q.high_speed_active) |-> $past(I_EVT.hs_done))
    else $error("hs active without negotiation");
  host_resume_a: assert property (I_HOST_ROLE && I_EVT.resume_seen && pwr_q.suspend_state
                                  |=> pwr_q.resume)
    else $error("host resume not set");
  soft_attach_a: assert property (!I_HOST_ROLE |-> O_LINE_OE_B == !pwr_q.soft_attach)
    else $error("line enable wrong");
  sop_len_a: assert property (I_DMA_EOP |=> O_WRITE_SOP_LEN && O_SOP_LEN == $past(pkt_total_q))
    else $error("sop length not written");

  irq_seen_c: cover property ($rose(O_IRQ));
  rxq_clear_c: cover property ($fell(rxq_irq_q));
  zlp_c: cover property (O_SEND_ZLP);
  suspend_c: cover property ($rose(pwr_q.suspend_state));

endmodule // usb_ctrl_regs
`default_nettype wire

// *** usb_regs_pkg.sv ***
`default_nettype none
package usb_regs_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_RX_DESC_PTR   = 8'h00;
  localparam logic [7:0] OFS_RX_BUF_ADDR   = 8'h04;
  localparam logic [7:0] OFS_RX_LENGTHS    = 8'h08;
  localparam logic [7:0] OFS_RX_BYTECNT    = 8'h0C;
  localparam logic [7:0] OFS_RX_COMP_PTR   = 8'h10;
  localparam logic [7:0] OFS_FUNC_ADDR     = 8'h14;
  localparam logic [7:0] OFS_POWER         = 8'h18;
  localparam logic [7:0] OFS_TX_IRQ_STAT   = 8'h1C;
  localparam logic [7:0] OFS_RX_IRQ_STAT   = 8'h20;
  localparam logic [7:0] OFS_TX_IRQ_EN     = 8'h24;
  localparam logic [7:0] OFS_RX_IRQ_EN     = 8'h28;
  localparam logic [7:0] OFS_WRAP_CTRL     = 8'h2C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_IN_PACKET   = 0;
  localparam int POS_MODE_BIT    = 0;
  localparam int POS_ENSUSP      = 0;
  localparam int POS_SUSPEND     = 1;
  localparam int POS_RESUME      = 2;
  localparam int POS_BUSRESET    = 3;
  localparam int POS_HS_ACTIVE   = 4;
  localparam int POS_HS_ALLOW    = 5;
  localparam int POS_SOFT_ATTACH = 6;
  localparam int POS_ISO_WAIT    = 7;
  localparam int POS_DIRECT_IRQ  = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_POWER  = 8'h20;
  localparam logic [6:0]  RST_FUNCTION_ADDRESS  = 7'h00;
  localparam logic [4:0]  RST_IRQ_EN = 5'h00;
  localparam logic [29:0] RST_PTR30  = 30'h00000000;

  // power management register image
  typedef struct packed {
    logic iso_wait_for_frame;
    logic soft_attach;
    logic high_speed_allow;
    logic high_speed_active;
    logic bus_reset;
    logic resume;
    logic suspend_state;
    logic suspend_output_enable;
  } power_t;

  // events arriving from the usb core
  typedef struct packed {
    logic       bus_reset_seen;
    logic       resume_seen;
    logic       suspend_seen;
    logic       hs_done;
    logic       sof_token;
    logic       in_token;
    logic [4:0] tx_irq_set;
    logic [4:0] rx_irq_set;
  } core_evt_t;

endpackage
`default_nettype wire
